// File: rtl/tpio_pkg.sv
// timer pin i/o mode decode: shared constants, field codes and carriers
// assumes one clock (mclk, 25 MHz) and a synchronous active-high reset
// ------------------------------------------------------------------
// Overview of operation
// - top bit 0 is compare; low 00 disables pin, 01 drives low on match
// - compare with low bits 10 drives pin high on match
// - compare with low bits 11 toggles pin on match from initial level
// - top bit 1, bits 2..0 000 capture on rising pin edge
// - top bit 1, bits 2..0 001 capture on falling pin edge
// - top bit 1, bit 2 0, bit 1 1 capture on both edges
// - channel 0 register d code 11xx captures on channel 1 count events
// - channel 1 prescale select 000 blocks the cascaded count capture
// - channel 1 register b code 11xx captures on register c events
// - buffer mode bit set silences register d compare and capture
// - initial pin level is loaded only while the counter is stopped
// - each i/o control register is 8-bit read/write, resets to zero
// ------------------------------------------------------------------
package tpio_pkg;

    // register indices on the plain register port
    localparam logic [2:0] OFS_CHAN0_IO_CTRL_CD = 3'h0;
    localparam logic [2:0] OFS_CHAN1_IO_CTRL    = 3'h1;
    localparam logic [2:0] OFS_CHAN2_IO_CTRL    = 3'h2;
    localparam logic [2:0] OFS_TIMER_CTRL       = 3'h3;
    localparam logic [2:0] OFS_PIN_STATUS       = 3'h4;

    localparam logic [7:0] IO_CTRL_RESET        = 8'h00;
    localparam logic [7:0] TIMER_CTRL_RESET     = 8'h00;

    // upper nibble holds the decoded field (d for chan 0, b for chan 1/2)
    localparam int FLD_LSB        = 4;
    // timer control fields
    localparam int CTL_BUF_BIT    = 0;
    localparam int CTL_START_LSB  = 1;
    localparam int CTL_PSC_LSB    = 4;
    localparam logic [2:0] PSC_UNDIVIDED = 3'h0;

    // field codes used by the checks
    localparam logic [3:0] FLD_CMP_CLR  = 4'h1;
    localparam logic [3:0] FLD_CMP_SET  = 4'h2;
    localparam logic [3:0] FLD_CMP_TGL  = 4'h3;
    localparam logic [3:0] FLD_CAP_RISE = 4'h8;
    localparam logic [3:0] FLD_CAP_FALL = 4'h9;
    localparam logic [1:0] FLD_CASCADE  = 2'h3;

    localparam int NUM_CHAN = 3;

    typedef struct packed {
        logic cmp_match;
        logic rise;
        logic fall;
        logic cascade;
        logic running;
        logic inhibit;
    } tpio_chan_in_type;

    typedef struct packed {
        logic level;
        logic oe;
        logic capture;
    } tpio_chan_out_type;

endpackage

// File: rtl/tpio_chan.sv
// one channel's pin decode: compare output level and capture strobe
// assumes edge pulses come from already synchronised pin samples
`timescale 1ns/1ps

module tpio_chan #(
    parameter bit HAS_CASCADE = 1'b1
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic [3:0]                  field,
    input  wire tpio_pkg::tpio_chan_in_type  cin,
    output tpio_pkg::tpio_chan_out_type      cout
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // buffer mode wins over every field code
    wire   is_cmp    = ~field[3] & ~cin.inhibit;
    wire   drive_nxt = is_cmp & (field[1:0] != 2'h0);
    // without a cascade source bit 2 is don't-care in capture mode
    wire   casc_sel  = HAS_CASCADE & field[2];
    wire   edge_hit  = field[1] ? (cin.rise | cin.fall)
                     : (field[0] ? cin.fall : cin.rise);
    wire   cap_nxt   = field[3] & ~cin.inhibit
                     & (casc_sel ? cin.cascade : edge_hit);
    logic  level_nxt;

    // compare match action, initial level while stopped
    always_comb begin
        level_nxt = cout.level;
        if (!cin.running) begin
            level_nxt = field[2];
        end else if (is_cmp && cin.cmp_match) begin
            case (field[1:0])
                2'h1:    level_nxt = 1'b0;
                2'h2:    level_nxt = 1'b1;
                2'h3:    level_nxt = ~cout.level;
                default: level_nxt = cout.level;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            cout <= '0;
        end else begin
            cout.level   <= level_nxt;
            cout.oe      <= drive_nxt;
            cout.capture <= cap_nxt;
        end
    end

endmodule // tpio_chan

// File: rtl/tpio_top.sv
// timer pin i/o mode decode for chan 0 reg d, chan 1 reg b, chan 2 reg b
// assumes compare matches and count events arrive on mclk; pins are async
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

module tpio_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // bit 0 chan0_pin_d, bit 1 chan1_pin_b, bit 2 chan2_pin_b
    input  wire logic [2:0]  pin_in,
    output logic      [2:0]  pin_out,
    output logic      [2:0]  pin_oe,
    // timer core events, same clock
    input  wire logic [2:0]  cmp_match,
    input  wire logic        chan1_count_tick,
    input  wire logic        chan0_regc_event,
    output logic      [2:0]  capture_strobe
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] chan0_io_ctrl_cd_r;
    logic [7:0] chan1_io_ctrl_r;
    logic [7:0] chan2_io_ctrl_r;
    logic [7:0] timer_ctrl_r;
    logic [7:0] reg_rdata_nxt;
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic [2:0] pin_prev_r;

    wire wr_ch0  = reg_wr & (reg_addr == tpio_pkg::OFS_CHAN0_IO_CTRL_CD);
    wire wr_ch1  = reg_wr & (reg_addr == tpio_pkg::OFS_CHAN1_IO_CTRL);
    wire wr_ch2  = reg_wr & (reg_addr == tpio_pkg::OFS_CHAN2_IO_CTRL);
    wire wr_ctl  = reg_wr & (reg_addr == tpio_pkg::OFS_TIMER_CTRL);

    // register writes, all fields read/write
    always_ff @(posedge mclk) begin
        if (rst) begin
            chan0_io_ctrl_cd_r <= tpio_pkg::IO_CTRL_RESET;
            chan1_io_ctrl_r    <= tpio_pkg::IO_CTRL_RESET;
            chan2_io_ctrl_r    <= tpio_pkg::IO_CTRL_RESET;
            timer_ctrl_r       <= tpio_pkg::TIMER_CTRL_RESET;
        end else begin
            if (wr_ch0) chan0_io_ctrl_cd_r <= reg_wdata;
            if (wr_ch1) chan1_io_ctrl_r    <= reg_wdata;
            if (wr_ch2) chan2_io_ctrl_r    <= reg_wdata;
            if (wr_ctl) timer_ctrl_r       <= reg_wdata;
        end
    end

    // read mux; unmapped addresses read zero
    wire [7:0] pin_status = {2'h0, pin_sync_r, pin_out};
    always_comb begin
        case (reg_addr)
            tpio_pkg::OFS_CHAN0_IO_CTRL_CD: reg_rdata_nxt = chan0_io_ctrl_cd_r;
            tpio_pkg::OFS_CHAN1_IO_CTRL:    reg_rdata_nxt = chan1_io_ctrl_r;
            tpio_pkg::OFS_CHAN2_IO_CTRL:    reg_rdata_nxt = chan2_io_ctrl_r;
            tpio_pkg::OFS_TIMER_CTRL:       reg_rdata_nxt = timer_ctrl_r;
            tpio_pkg::OFS_PIN_STATUS:       reg_rdata_nxt = pin_status;
            default:                        reg_rdata_nxt = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? reg_rdata_nxt : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------
    // first stage feeds only the second; edges come from stages two and three
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
            pin_prev_r <= 3'h0;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    wire [2:0] pin_rise = pin_sync_r & ~pin_prev_r;
    wire [2:0] pin_fall = ~pin_sync_r & pin_prev_r;

    // ------------------------------------------------------------------
    // channel controls
    // ------------------------------------------------------------------
    wire [3:0] fld0      = chan0_io_ctrl_cd_r[tpio_pkg::FLD_LSB +: 4];
    wire [3:0] fld1      = chan1_io_ctrl_r[tpio_pkg::FLD_LSB +: 4];
    wire [3:0] fld2      = chan2_io_ctrl_r[tpio_pkg::FLD_LSB +: 4];
    wire       buf_mode  = timer_ctrl_r[tpio_pkg::CTL_BUF_BIT];
    wire [2:0] running   = timer_ctrl_r[tpio_pkg::CTL_START_LSB +: 3];
    wire [2:0] psc1_sel  = timer_ctrl_r[tpio_pkg::CTL_PSC_LSB +: 3];
    // undivided clock gives a tick every cycle, so that source is void
    wire       tick_ok   = chan1_count_tick
                         & (psc1_sel != tpio_pkg::PSC_UNDIVIDED);
    wire [2:0] cascade   = {1'b0, chan0_regc_event, tick_ok};
    wire [2:0] inhibit   = {2'h0, buf_mode};
    wire [3:0] fld [tpio_pkg::NUM_CHAN];
    assign fld[0] = fld0;
    assign fld[1] = fld1;
    assign fld[2] = fld2;

    tpio_pkg::tpio_chan_out_type chan_out [tpio_pkg::NUM_CHAN];

    // one decoder per channel; chan 2 has no cascade source
    for (genvar i = 0; i < tpio_pkg::NUM_CHAN; i++) begin : g_chan
        tpio_pkg::tpio_chan_in_type cin;
        assign cin.cmp_match = cmp_match[i];
        assign cin.rise      = pin_rise[i];
        assign cin.fall      = pin_fall[i];
        assign cin.cascade   = cascade[i];
        assign cin.running   = running[i];
        assign cin.inhibit   = inhibit[i];

        tpio_chan #(
            .HAS_CASCADE (i != 2)
        ) u_chan (
            .mclk  (mclk),
            .rst   (rst),
            .field (fld[i]),
            .cin   (cin),
            .cout  (chan_out[i])
        );

        assign pin_out[i]        = chan_out[i].level;
        assign pin_oe[i]         = chan_out[i].oe;
        assign capture_strobe[i] = chan_out[i].capture;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_wr_ch1;
        reg_wr && reg_addr == tpio_pkg::OFS_CHAN1_IO_CTRL;
    endsequence
    sequence s_rd_ch1;
        reg_rd && reg_addr == tpio_pkg::OFS_CHAN1_IO_CTRL;
    endsequence
    sequence s_cmp_hit(logic [3:0] code);
        running[1] && fld1 == code && cmp_match[1];
    endsequence

    a_disabled_no_drive: assert property (
        !fld1[3] && fld1[1:0] == 2'h0 |=> !pin_oe[1])
        else $error("pin driven while output disabled");

    a_clear_on_match: assert property (
        s_cmp_hit(tpio_pkg::FLD_CMP_CLR) |=> !pin_out[1] && pin_oe[1])
        else $error("match did not drive pin low");

    a_set_on_match: assert property (
        s_cmp_hit(tpio_pkg::FLD_CMP_SET) |=> pin_out[1] && pin_oe[1])
        else $error("match did not drive pin high");

    a_toggle_on_match: assert property (
        s_cmp_hit(tpio_pkg::FLD_CMP_TGL) |=> pin_out[1] != $past(pin_out[1]))
        else $error("match did not toggle pin");

    a_rise_capture: assert property (
        fld1 == tpio_pkg::FLD_CAP_RISE |-> ##1 capture_strobe[1] == $past(pin_rise[1]))
        else $error("rising edge capture wrong");

    a_fall_capture: assert property (
        fld1 == tpio_pkg::FLD_CAP_FALL |-> ##1 capture_strobe[1] == $past(pin_fall[1]))
        else $error("falling edge capture wrong");

    a_both_capture: assert property (
        fld1[3:1] == 3'h5 && (pin_rise[1] || pin_fall[1]) |=> capture_strobe[1])
        else $error("both edge capture missed");

    a_cascade_tick: assert property (
        fld0[3:2] == tpio_pkg::FLD_CASCADE && !buf_mode
        |-> ##1 capture_strobe[0] == $past(tick_ok))
        else $error("cascade count capture wrong");

    a_prescale_block: assert property (
        fld0[3:2] == tpio_pkg::FLD_CASCADE && psc1_sel == tpio_pkg::PSC_UNDIVIDED
        |=> !capture_strobe[0])
        else $error("capture from undivided count clock");

    a_regc_cascade: assert property (
        fld1[3:2] == tpio_pkg::FLD_CASCADE
        |-> ##1 capture_strobe[1] == $past(chan0_regc_event))
        else $error("register c cascade capture wrong");

    a_buffer_quiet: assert property (
        buf_mode |=> !pin_oe[0] && !capture_strobe[0])
        else $error("buffer register still active");

    a_ch2_bit2_ignored: assert property (
        fld2[3] && fld2[1:0] == 2'h0 |-> ##1 capture_strobe[2] == $past(pin_rise[2]))
        else $error("chan 2 capture ignores edge");

    a_initial_level: assert property (
        !running[1] ##1 !running[1] |-> pin_out[1] == $past(fld1[2]))
        else $error("initial level not loaded while stopped");

    a_reg_readback: assert property (
        s_wr_ch1 ##1 s_rd_ch1 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("io control readback mismatch");

endmodule // tpio_top

// File: testbench/tpio_far_model.sv
// far-side model: timer pins and neighbouring-channel event sources
// assumes requests from the bench change right after a rising mclk edge
`timescale 1ns/1ps

module tpio_far_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [2:0]  pin_req,
    input  wire logic [4:0]  ev_req,
    output logic      [2:0]  pin_in,
    output logic      [2:0]  cmp_match,
    output logic             chan1_count_tick,
    output logic             chan0_regc_event
);
    // --------------------------------------------------------------
    // pins and events
    // --------------------------------------------------------------
    // one register stage: the far side launches on the edge, never mid-cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_in           <= 3'h0;
            cmp_match        <= 3'h0;
            chan1_count_tick <= 1'b0;
            chan0_regc_event <= 1'b0;
        end else begin
            pin_in           <= pin_req;
            cmp_match        <= ev_req[2:0]; // one-cycle pulses
            chan1_count_tick <= ev_req[3];
            chan0_regc_event <= ev_req[4];
        end
    end
endmodule // tpio_far_model

// File: testbench/tb_timer_pin_io_mode_decode.sv
// self-checking bench for the timer pin i/o decode block
// assumes the register indices and timer_ctrl layout of tpio_pkg
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_timer_pin_io_mode_decode;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [2:0]  pin_in, pin_out, pin_oe, cmp_match, capture_strobe;
    logic        chan1_count_tick, chan0_regc_event;
    logic [2:0]  pin_req = 3'h0;
    logic [4:0]  ev_req = 5'h00;
    logic [7:0]  cnt [3];
    int          err_count = 0;
    int          check_count = 0;

    always #20 mclk = ~mclk; // 25 MHz

    tpio_top DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .cmp_match(cmp_match),
        .chan1_count_tick(chan1_count_tick), .chan0_regc_event(chan0_regc_event),
        .capture_strobe(capture_strobe));

    tpio_far_model far (.mclk(mclk), .rst(rst), .pin_req(pin_req), .ev_req(ev_req),
        .pin_in(pin_in), .cmp_match(cmp_match), .chan1_count_tick(chan1_count_tick),
        .chan0_regc_event(chan0_regc_event));

    // --------------------------------------------------------------
    // capture strobe counters
    // --------------------------------------------------------------
    // counting, not sampling, so a strobe one cycle early or late still counts once
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i] <= rst ? 8'h00 : cnt[i] + {7'h00, capture_strobe[i]};
        end
    end

    // --------------------------------------------------------------
    // register port and stimulus tasks
    // --------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // write then read back with no idle cycle between the two strobes
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] wd, output logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= wd;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge mclk);
        reg_rd    <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // one pin pulse: count captures after the rising, then the falling edge
    task automatic cap(input int ch, input logic [7:0] fld, input int er, input int ef);
        logic [7:0] b;
        wr(3'(ch), fld);
        idle(8);
        b = cnt[ch];
        pin_req[ch] <= 1'b1;
        idle(8);
        `CHK(8'(cnt[ch] - b), 8'(er))
        pin_req[ch] <= 1'b0;
        idle(8);
        `CHK(8'(cnt[ch] - b), 8'(er + ef))
    endtask

    // one event pulse from the far side, then the capture count of one channel
    task automatic pulse(input logic [4:0] m, input int ch, input int ex);
        logic [7:0] b;
        b = cnt[ch];
        @(posedge mclk);
        ev_req <= m;
        @(posedge mclk);
        ev_req <= 5'h00;
        idle(5);
        @(negedge mclk);
        `CHK(8'(cnt[ch] - b), 8'(ex))
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(40 * 100000);
        err_count++;
        complete_run();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [3:0] c;
        logic       lvl;
        idle(10);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd(3'(a), d);
            `CHK(d, 8'h00)
            wr(3'(a), 8'h5a);
            rd(3'(a), d);
            `CHK(d, 8'h5a)
            wr(3'(a), 8'h00);
        end
        rd(3'h5, d);
        `CHK(d, 8'h00)
        // back-to-back strobes: the read sees the write of the cycle before
        wr_rd(3'h1, 8'ha5, d);
        `CHK(d, 8'ha5)
        wr(3'h1, 8'h00);
        // every compare code on channel 1: initial level, then one match
        for (int k = 0; k < 8; k++) begin
            c = 4'(k);
            wr(3'h3, 8'h00);
            wr(3'h1, {c, 4'h0});
            idle(3);
            `CHK(pin_out[1], c[2])
            wr(3'h3, 8'h04);
            pulse(5'h02, 1, 0);
            lvl = (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : ~c[2];
            if (c[1:0] != 2'h0) `CHK(pin_out[1], lvl)
            `CHK(pin_oe[1], (c[1:0] != 2'h0))
        end
        wr(3'h3, 8'h00);
        cap(2, 8'h80, 1, 0);
        cap(2, 8'h90, 0, 1);
        cap(2, 8'ha0, 1, 1);
        cap(2, 8'hb0, 1, 1);
        cap(2, 8'hc0, 1, 0);
        cap(2, 8'hd0, 0, 1);
        cap(2, 8'he0, 1, 1);
        cap(0, 8'h80, 1, 0);
        cap(0, 8'h90, 0, 1);
        cap(1, 8'hb0, 1, 1);
        cap(1, 8'h80, 1, 0);
        cap(1, 8'h90, 0, 1);
        // cascaded sources: divided prescale, then undivided
        wr(3'h3, 8'h10);
        cap(0, 8'hc0, 0, 0);
        pulse(5'h08, 0, 1);
        wr(3'h3, 8'h00);
        pulse(5'h08, 0, 0);
        wr(3'h1, 8'hc0);
        pulse(5'h10, 1, 1);
        cap(1, 8'hc0, 0, 0);
        // buffer mode silences register d entirely
        wr(3'h3, 8'h01);
        cap(0, 8'h80, 0, 0);
        wr(3'h0, 8'h10);
        wr(3'h3, 8'h03);
        pulse(5'h01, 0, 0);
        `CHK(pin_oe[0], 1'b0)
        // status: stopped chans 1 and 2 show field bit 2, then a synced pin
        rd(3'h4, d);
        `CHK(d, 8'h06)
        @(posedge mclk);
        pin_req <= 3'h4;
        idle(4);
        rd(3'h4, d);
        `CHK(d, 8'h26)
        complete_run();
    end
endmodule // tb_timer_pin_io_mode_decode
